// ### verilog/csbcc_top.sv
// Status-driven bus command controller: decode, cycle sequencing and command drivers
`default_nettype none

module csbcc_top (
    input wire logic MCLK_IN,                        // System clock, 100 MHz
    input wire logic RST_IN,                         // Asynchronous reset, active high
    input wire logic BUS_CLK_IN,                     // Processor clock, sampled
    input wire logic STATUS_BIT_ZERO_IN,             // Processor status bit 0
    input wire logic STATUS_BIT_ONE_IN,              // Processor status bit 1
    input wire logic STATUS_BIT_TWO_IN,              // Processor status bit 2
    input wire logic BUS_GRANT_GATE_N_IN,            // Arbiter grant, low when bus free
    input wire logic COMMAND_QUALIFIER_IN,           // High lets commands operate
    input wire logic IO_BUS_MODE_STRAP_IN,           // High selects I/O bus mode
    output logic ADDR_LATCH_STROBE_OUT,              // Address latch strobe, active high
    output logic DATA_TRANSCEIVER_ENABLE_OUT,        // Data transceiver enable, active high
    output logic TRANSFER_DIRECTION_OUT,             // High transmit, low receive
    output logic CASCADE_OR_PERIPH_ENABLE_OUT,       // Cascade enable or peripheral enable
    output logic MEM_READ_STROBE_N_OUT,              // Memory read command
    output logic MEM_WRITE_STROBE_N_OUT,             // Memory write command
    output logic EARLY_MEM_WRITE_N_OUT,              // Advanced memory write command
    output logic IO_READ_STROBE_N_OUT,               // I/O read command
    output logic IO_WRITE_STROBE_N_OUT,              // I/O write command
    output logic EARLY_IO_WRITE_N_OUT,               // Advanced I/O write command
    output logic INTERRUPT_ACK_STROBE_N_OUT,         // Interrupt acknowledge command
    output logic MEM_CMD_OE_OUT,                     // Drive enable, memory command pins
    output logic IO_CMD_OE_OUT                       // Drive enable, I/O command pins
);

    typedef struct packed {
        logic [csbcc_pkg::SYNC_W-1:0] sync1;
        logic [csbcc_pkg::SYNC_W-1:0] sync2;
        logic clk_prev;
        csbcc_pkg::csbcc_phase_e phase;
        logic [2:0] code;
        logic [csbcc_pkg::GRANT_CNT_W-1:0] grant_cnt;
        logic grant_ok;
        logic ale;
        logic data_transceiver_enable;
        logic dtr;
        logic share;
        logic mrd_n;
        logic mwr_n;
        logic amw_n;
        logic ior_n;
        logic iow_n;
        logic aiow_n;
        logic interrupt_ack_strobe_n_n;
        logic mem_oe;
        logic io_oe;
    } csbcc_state_s;

    csbcc_state_s s;
    csbcc_state_s next_s;

    logic bus_rise;
    logic bus_fall;
    logic [2:0] live_code;
    logic live_active;
    logic strap;
    logic qual;
    logic grant_n;
    logic in_cycle;
    logic cmd_phase;
    logic full_phase;
    logic io_ok;
    logic mem_ok;
    csbcc_pkg::csbcc_cmd_e kind;

    always_comb begin
        next_s = s;
        // Every input pin but the clock and reset passes two flops before anything looks at it
        next_s.sync1 = {IO_BUS_MODE_STRAP_IN, COMMAND_QUALIFIER_IN, BUS_GRANT_GATE_N_IN,
                        STATUS_BIT_TWO_IN, STATUS_BIT_ONE_IN, STATUS_BIT_ZERO_IN, BUS_CLK_IN};
        next_s.sync2 = s.sync1;
        next_s.clk_prev = s.sync2[csbcc_pkg::BIT_BUS_CLK];

        bus_rise = s.sync2[csbcc_pkg::BIT_BUS_CLK] & ~s.clk_prev;
        bus_fall = ~s.sync2[csbcc_pkg::BIT_BUS_CLK] & s.clk_prev;
        live_code = {s.sync2[csbcc_pkg::BIT_STATUS2], s.sync2[csbcc_pkg::BIT_STATUS1],
                     s.sync2[csbcc_pkg::BIT_STATUS0]};
        live_active = live_code != csbcc_pkg::CODE_PASSIVE;
        strap = s.sync2[csbcc_pkg::BIT_STRAP];
        qual = s.sync2[csbcc_pkg::BIT_QUALIFIER];
        grant_n = s.sync2[csbcc_pkg::BIT_GRANT_N];

        // Grant interval: counted only while the grant stays low
        if (grant_n) begin
            next_s.grant_cnt = '0;
        end else if (s.grant_cnt != csbcc_pkg::GRANT_WAIT) begin
            next_s.grant_cnt = s.grant_cnt + 1'b1;
        end
        next_s.grant_ok = next_s.grant_cnt == csbcc_pkg::GRANT_WAIT;

        // Machine-cycle sequencing on processor clock edges
        unique case (s.phase)
            csbcc_pkg::CSBCC_IDLE: begin
                if (bus_rise && live_active) begin
                    next_s.phase = csbcc_pkg::CSBCC_ADDR;
                    next_s.code = live_code;
                end
            end
            csbcc_pkg::CSBCC_ADDR: begin
                next_s.code = live_code;
                if (bus_fall) begin
                    // Strobe falls here; this is the held copy used for command decode
                    next_s.phase = csbcc_pkg::CSBCC_ADDR_HOLD;
                end
            end
            csbcc_pkg::CSBCC_ADDR_HOLD: begin
                if (bus_rise) begin
                    next_s.phase = csbcc_pkg::CSBCC_EARLY;
                end
            end
            csbcc_pkg::CSBCC_EARLY: begin
                if (bus_rise) begin
                    next_s.phase = live_active ? csbcc_pkg::CSBCC_FULL : csbcc_pkg::CSBCC_IDLE;
                end
            end
            csbcc_pkg::CSBCC_FULL: begin
                if (bus_rise && !live_active) begin
                    next_s.phase = csbcc_pkg::CSBCC_IDLE;
                end
            end
            default: begin
                next_s.phase = csbcc_pkg::CSBCC_IDLE;
            end
        endcase

        kind = csbcc_pkg::csbcc_decode(next_s.code);
        in_cycle = next_s.phase != csbcc_pkg::CSBCC_IDLE;
        cmd_phase = next_s.phase == csbcc_pkg::CSBCC_EARLY ||
                    next_s.phase == csbcc_pkg::CSBCC_FULL;
        full_phase = next_s.phase == csbcc_pkg::CSBCC_FULL;
        // I/O bus mode needs no grant for I/O; memory always waits for it
        io_ok = qual & (strap | next_s.grant_ok);
        mem_ok = qual & next_s.grant_ok;

        // Halt and passive decode to no strobe at all; low qualifier drives high
        next_s.mrd_n = ~(cmd_phase && kind == csbcc_pkg::CSBCC_MEM_READ && mem_ok);
        next_s.amw_n = ~(cmd_phase && kind == csbcc_pkg::CSBCC_MEM_WRITE && mem_ok);
        next_s.mwr_n = ~(full_phase && kind == csbcc_pkg::CSBCC_MEM_WRITE && mem_ok);
        next_s.ior_n = ~(cmd_phase && kind == csbcc_pkg::CSBCC_IO_READ && io_ok);
        next_s.aiow_n = ~(cmd_phase && kind == csbcc_pkg::CSBCC_IO_WRITE && io_ok);
        next_s.iow_n = ~(full_phase && kind == csbcc_pkg::CSBCC_IO_WRITE && io_ok);
        next_s.interrupt_ack_strobe_n_n = ~(cmd_phase && kind == csbcc_pkg::CSBCC_INT_ACK && io_ok);

        // Memory drivers, and I/O drivers outside I/O bus mode, float as soon as the grant is seen gone
        next_s.mem_oe = next_s.grant_ok;
        next_s.io_oe = strap | next_s.grant_ok;

        next_s.ale = next_s.phase == csbcc_pkg::CSBCC_ADDR;
        next_s.dtr = ~(in_cycle && csbcc_pkg::csbcc_is_read(kind));

        if (strap) begin
            // Memory traffic on the system transceiver, I/O traffic on the peripheral one
            next_s.data_transceiver_enable = cmd_phase && qual && (kind == csbcc_pkg::CSBCC_MEM_READ ||
                         kind == csbcc_pkg::CSBCC_MEM_WRITE);
            next_s.share = ~(cmd_phase && qual && csbcc_pkg::csbcc_is_io(kind));
        end else begin
            next_s.data_transceiver_enable = cmd_phase && qual && kind != csbcc_pkg::CSBCC_HALT;
            // Masking the first of the two acknowledge cycles is left to external logic
            next_s.share = next_s.ale && kind == csbcc_pkg::CSBCC_INT_ACK;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s <= '{sync1: '0, sync2: '0, clk_prev: 1'b0, phase: csbcc_pkg::CSBCC_IDLE,
                   code: csbcc_pkg::CODE_PASSIVE, grant_cnt: '0, grant_ok: 1'b0,
                   ale: 1'b0, data_transceiver_enable: 1'b0, dtr: 1'b1, share: 1'b0,
                   mrd_n: 1'b1, mwr_n: 1'b1, amw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1,
                   aiow_n: 1'b1, interrupt_ack_strobe_n_n: 1'b1, mem_oe: 1'b0, io_oe: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign ADDR_LATCH_STROBE_OUT = s.ale;
    assign DATA_TRANSCEIVER_ENABLE_OUT = s.data_transceiver_enable;
    assign TRANSFER_DIRECTION_OUT = s.dtr;
    assign CASCADE_OR_PERIPH_ENABLE_OUT = s.share;
    assign MEM_READ_STROBE_N_OUT = s.mrd_n;
    assign MEM_WRITE_STROBE_N_OUT = s.mwr_n;
    assign EARLY_MEM_WRITE_N_OUT = s.amw_n;
    assign IO_READ_STROBE_N_OUT = s.ior_n;
    assign IO_WRITE_STROBE_N_OUT = s.iow_n;
    assign EARLY_IO_WRITE_N_OUT = s.aiow_n;
    assign INTERRUPT_ACK_STROBE_N_OUT = s.interrupt_ack_strobe_n_n;
    assign MEM_CMD_OE_OUT = s.mem_oe;
    assign IO_CMD_OE_OUT = s.io_oe;

endmodule : csbcc_top

`default_nettype wire

// ### verilog/csbcc_pkg.sv
// Constants, types and decode helpers for the status-driven bus command controller
//
// Summary of operation
// - Decode three status bits into one command
// - Passive status keeps every command strobe high
// - Processor clock edges time all outputs except the command drive enables
// - Address strobe high, address taken on fall
// - Address strobe every cycle, latches status code
// - Data enable high while transceivers drive
// - Direction high for writes, low for reads
// - Commands enabled 110 to 250 ns after grant
// - Grant removal floats command drivers immediately
// - I/O bus mode ignores grant for I/O
// - Low qualifier forces commands, data enables inactive
// - Forced outputs driven inactive, never floated
// - Strap high selects I/O bus mode
// - System bus mode waits for grant interval
// - Early I/O write low with read timing
// - Early memory write low with read timing
// - All command strobes are active low
// - Interrupt acknowledge asks for vector on bus
// - Strap low: shared pin is cascade enable
`default_nettype none

package csbcc_pkg;

    // Positions inside the synchroniser vector
    localparam int unsigned SYNC_W = 7;
    localparam int unsigned BIT_BUS_CLK = 0;
    localparam int unsigned BIT_STATUS0 = 1;
    localparam int unsigned BIT_STATUS1 = 2;
    localparam int unsigned BIT_STATUS2 = 3;
    localparam int unsigned BIT_GRANT_N = 4;
    localparam int unsigned BIT_QUALIFIER = 5;
    localparam int unsigned BIT_STRAP = 6;

    // Grant-to-command interval
    localparam int unsigned MCLK_PERIOD_NS = 10;
    localparam int unsigned GRANT_MIN_NS = 110;
    localparam int unsigned GRANT_MAX_NS = 250;
    localparam int unsigned GRANT_MIN_CYC = (GRANT_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned GRANT_MAX_CYC = GRANT_MAX_NS / MCLK_PERIOD_NS;
    localparam int unsigned GRANT_CNT_W = 5;
    localparam logic [GRANT_CNT_W-1:0] GRANT_WAIT = GRANT_CNT_W'(GRANT_MIN_CYC);

    localparam logic [2:0] CODE_PASSIVE = 3'h7;

    typedef enum logic [2:0] {
        CSBCC_INT_ACK,
        CSBCC_IO_READ,
        CSBCC_IO_WRITE,
        CSBCC_HALT,
        CSBCC_MEM_READ,
        CSBCC_MEM_WRITE,
        CSBCC_PASSIVE
    } csbcc_cmd_e;

    typedef enum logic [2:0] {
        CSBCC_IDLE,
        CSBCC_ADDR,
        CSBCC_ADDR_HOLD,
        CSBCC_EARLY,
        CSBCC_FULL
    } csbcc_phase_e;

    // Code order is status two, one, zero
    function automatic csbcc_cmd_e csbcc_decode(input logic [2:0] code);
        csbcc_cmd_e kind;
        unique case (code)
            3'h0: kind = CSBCC_INT_ACK;
            3'h1: kind = CSBCC_IO_READ;
            3'h2: kind = CSBCC_IO_WRITE;
            3'h3: kind = CSBCC_HALT;
            3'h4, 3'h5: kind = CSBCC_MEM_READ;
            3'h6: kind = CSBCC_MEM_WRITE;
            3'h7: kind = CSBCC_PASSIVE;
        endcase
        return kind;
    endfunction : csbcc_decode

    function automatic logic csbcc_is_read(input csbcc_cmd_e kind);
        return kind == CSBCC_INT_ACK || kind == CSBCC_IO_READ || kind == CSBCC_MEM_READ;
    endfunction : csbcc_is_read

    function automatic logic csbcc_is_io(input csbcc_cmd_e kind);
        return kind == CSBCC_INT_ACK || kind == CSBCC_IO_READ || kind == CSBCC_IO_WRITE;
    endfunction : csbcc_is_io

endpackage : csbcc_pkg

`default_nettype wire

// ### tb/csbcc_props.sv
// Port timing checker for the bus command controller
`default_nettype none
module csbcc_props (
    input wire logic MCLK_IN, RST_IN, BUS_GRANT_GATE_N_IN, COMMAND_QUALIFIER_IN,
    input wire logic IO_BUS_MODE_STRAP_IN, STATUS_BIT_ZERO_IN, STATUS_BIT_ONE_IN,
    input wire logic STATUS_BIT_TWO_IN, ADDR_LATCH_STROBE_OUT, DATA_TRANSCEIVER_ENABLE_OUT,
    input wire logic TRANSFER_DIRECTION_OUT, CASCADE_OR_PERIPH_ENABLE_OUT,
    input wire logic MEM_READ_STROBE_N_OUT, MEM_WRITE_STROBE_N_OUT, EARLY_MEM_WRITE_N_OUT,
    input wire logic IO_READ_STROBE_N_OUT, IO_WRITE_STROBE_N_OUT, EARLY_IO_WRITE_N_OUT,
    input wire logic INTERRUPT_ACK_STROBE_N_OUT, MEM_CMD_OE_OUT, IO_CMD_OE_OUT
);
    wire logic [6:0] stb = {MEM_READ_STROBE_N_OUT, MEM_WRITE_STROBE_N_OUT,
        EARLY_MEM_WRITE_N_OUT, IO_READ_STROBE_N_OUT, IO_WRITE_STROBE_N_OUT,
        EARLY_IO_WRITE_N_OUT, INTERRUPT_ACK_STROBE_N_OUT};
    wire logic passive = STATUS_BIT_TWO_IN & STATUS_BIT_ONE_IN & STATUS_BIT_ZERO_IN;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    sequence grant_low8;
        !BUS_GRANT_GATE_N_IN [*8];
    endsequence
    passive_idle_a: assert property (passive [*8] ##1 passive [*8] |-> &stb)
        else $error("command strobe low while status passive");
    qual_forces_a: assert property (!COMMAND_QUALIFIER_IN [*5]
        |-> &stb && !DATA_TRANSCEIVER_ENABLE_OUT) else $error("qualifier low ignored");
    read_dir_a: assert property ($fell(MEM_READ_STROBE_N_OUT) || $fell(IO_READ_STROBE_N_OUT)
        || $fell(INTERRUPT_ACK_STROBE_N_OUT) |-> !TRANSFER_DIRECTION_OUT)
        else $error("read strobe with transmit direction");
    write_dir_a: assert property ($fell(MEM_WRITE_STROBE_N_OUT) || $fell(IO_WRITE_STROBE_N_OUT)
        |-> TRANSFER_DIRECTION_OUT) else $error("write strobe with receive direction");
    early_mem_a: assert property ($fell(MEM_WRITE_STROBE_N_OUT) |-> !$past(EARLY_MEM_WRITE_N_OUT))
        else $error("memory write without early strobe ahead");
    early_io_a: assert property ($fell(IO_WRITE_STROBE_N_OUT) |-> !$past(EARLY_IO_WRITE_N_OUT))
        else $error("io write without early strobe ahead");
    grant_min_a: assert property ($rose(MEM_CMD_OE_OUT) |-> !$past(BUS_GRANT_GATE_N_IN, 11))
        else $error("command drive enabled too soon after grant");
    grant_max_a: assert property (grant_low8 ##1 grant_low8 ##1 grant_low8
        ##1 !BUS_GRANT_GATE_N_IN |-> MEM_CMD_OE_OUT) else $error("command drive late after grant");
    grant_drop_a: assert property ($rose(BUS_GRANT_GATE_N_IN) |-> ##[1:4] !MEM_CMD_OE_OUT)
        else $error("command drive kept after grant removed");
    io_mode_oe_a: assert property (IO_BUS_MODE_STRAP_IN [*5] |-> IO_CMD_OE_OUT)
        else $error("io commands not driven in io bus mode");
    ale_pulse_a: assert property ($rose(ADDR_LATCH_STROBE_OUT)
        |-> ##[1:16] !ADDR_LATCH_STROBE_OUT) else $error("address strobe never falls");
    cascade_ale_a: assert property (!IO_BUS_MODE_STRAP_IN [*5] ##0 CASCADE_OR_PERIPH_ENABLE_OUT
        |-> ADDR_LATCH_STROBE_OUT) else $error("cascade enable outside address phase");
    cover property ($fell(MEM_WRITE_STROBE_N_OUT));
    cover property ($fell(INTERRUPT_ACK_STROBE_N_OUT));
    cover property ($rose(MEM_CMD_OE_OUT));
    cover property (CASCADE_OR_PERIPH_ENABLE_OUT && !IO_BUS_MODE_STRAP_IN);
endmodule : csbcc_props
bind csbcc_top csbcc_props u_props (.MCLK_IN, .RST_IN, .BUS_GRANT_GATE_N_IN,
    .COMMAND_QUALIFIER_IN, .IO_BUS_MODE_STRAP_IN, .STATUS_BIT_ZERO_IN, .STATUS_BIT_ONE_IN,
    .STATUS_BIT_TWO_IN, .ADDR_LATCH_STROBE_OUT, .DATA_TRANSCEIVER_ENABLE_OUT,
    .TRANSFER_DIRECTION_OUT, .CASCADE_OR_PERIPH_ENABLE_OUT, .MEM_READ_STROBE_N_OUT,
    .MEM_WRITE_STROBE_N_OUT, .EARLY_MEM_WRITE_N_OUT, .IO_READ_STROBE_N_OUT,
    .IO_WRITE_STROBE_N_OUT, .EARLY_IO_WRITE_N_OUT, .INTERRUPT_ACK_STROBE_N_OUT,
    .MEM_CMD_OE_OUT, .IO_CMD_OE_OUT);
`default_nettype wire

// ### tb/csbcc_cpu_model.sv
// Processor model: bus clock and status code sequencing
`default_nettype none
module csbcc_cpu_model (
    input wire logic clk_in,       // Bench clock
    input wire logic slow_in,      // Stretches bus clock phases
    output logic bus_clk_out,      // Processor clock
    output logic [2:0] status_out  // Status code, bit two first
);
    timeunit 1ns;
    timeprecision 1ps;
    int phase_cnt = 0;
    initial begin
        bus_clk_out = 1'b0;
        status_out = 3'h7;
    end
    // Phases of 4 or 6 bench cycles stay above the synchroniser minimum
    always @(negedge clk_in) begin
        if (phase_cnt >= (slow_in ? 5 : 3)) begin
            phase_cnt <= 0;
            bus_clk_out <= ~bus_clk_out;
        end else begin
            phase_cnt <= phase_cnt + 1;
        end
    end
    // Code held through the third rise so the late write phase is reached
    task automatic run(input logic [2:0] code);
        @(posedge bus_clk_out);
        status_out <= code;
        repeat (3) @(posedge bus_clk_out);
        status_out <= 3'h7;
        @(posedge bus_clk_out);
    endtask : run
endmodule : csbcc_cpu_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the bus command controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, grant_n = 1'b0, qual = 1'b1, strap = 1'b0, slow = 1'b0;
    logic bclk, ale, data_transceiver_enable, dir, moe, ioe, mon = 1'b0, ale_seen, den_seen, dir_low;
    logic share, shr_seen;
    logic [2:0] st;
    logic [6:0] low_seen;
    wire [6:0] stb;
    int fail_count = 0, compares = 0, cycles = 0;
    int tbl[8] = '{1, 8, 6, 0, 64, 64, 48, 0};
    always #5 clk = ~clk;
    csbcc_cpu_model u_cpu (.clk_in(clk), .slow_in(slow), .bus_clk_out(bclk), .status_out(st));
    csbcc_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .BUS_CLK_IN(bclk),
        .STATUS_BIT_ZERO_IN(st[0]), .STATUS_BIT_ONE_IN(st[1]), .STATUS_BIT_TWO_IN(st[2]),
        .BUS_GRANT_GATE_N_IN(grant_n), .COMMAND_QUALIFIER_IN(qual),
        .IO_BUS_MODE_STRAP_IN(strap), .ADDR_LATCH_STROBE_OUT(ale),
        .DATA_TRANSCEIVER_ENABLE_OUT(data_transceiver_enable), .TRANSFER_DIRECTION_OUT(dir),
        .CASCADE_OR_PERIPH_ENABLE_OUT(share), .MEM_READ_STROBE_N_OUT(stb[6]),
        .MEM_WRITE_STROBE_N_OUT(stb[5]), .EARLY_MEM_WRITE_N_OUT(stb[4]),
        .IO_READ_STROBE_N_OUT(stb[3]), .IO_WRITE_STROBE_N_OUT(stb[2]),
        .EARLY_IO_WRITE_N_OUT(stb[1]), .INTERRUPT_ACK_STROBE_N_OUT(stb[0]),
        .MEM_CMD_OE_OUT(moe), .IO_CMD_OE_OUT(ioe));
    task automatic end_of_test();
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string name, input logic [6:0] seen, input logic [6:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    always @(posedge clk) begin
        if (mon) begin
            low_seen <= low_seen | ~stb;
            ale_seen <= ale_seen | ale;
            den_seen <= den_seen | data_transceiver_enable;
            dir_low <= dir_low | ~dir;
            // Active level of the shared pin flips with the strap
            shr_seen <= shr_seen | (share ^ strap);
        end
    end
    // Whole run needs well under 10000 cycles
    always @(negedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic setup(input logic s, input logic g, input logic q);
        int n;
        n = 0;
        @(negedge clk);
        strap = s;
        qual = q;
        if (g !== grant_n) begin
            grant_n = g;
            while (moe !== !g && n < 40) begin
                @(negedge clk);
                n++;
            end
            chk("drive delay", 7'(g ? n <= 5 : n >= 11 && n <= 25), 7'h01);
        end
        repeat (30) @(negedge clk);
        chk("mem drive", 7'(moe), 7'(!g));
        chk("io drive", 7'(ioe), 7'(!g || s));
    endtask : setup
    task automatic cyc(input int code);
        logic go;
        go = qual && (code >= 4 ? !grant_n : (!grant_n || strap));
        @(negedge clk);
        low_seen = 7'h00;
        {ale_seen, den_seen, dir_low, shr_seen} = 4'h0;
        mon = 1'b1;
        u_cpu.run(code[2:0]);
        repeat (8) @(negedge clk);
        mon = 1'b0;
        chk("strobes", low_seen, go ? 7'(tbl[code]) : 7'h00);
        chk("addr strobe", 7'(ale_seen), 7'(code != 7));
        if (code != 3 && code != 7)
            chk("data enable", 7'(den_seen), 7'(qual && (code >= 4 || !strap)));
        chk("direction", 7'(dir_low), 7'(code inside {0, 1, 4, 5}));
        chk("shared enable", 7'(shr_seen), 7'(strap ? qual && code <= 2 : code == 0));
    endtask : cyc
    initial begin
        logic [2:0] cfg [4] = '{3'h1, 3'h0, 3'h7, 3'h3};
        logic [31:0] r;
        r = $urandom(32'h2384a2ca);
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        for (int m = 0; m < 4; m++) begin
            setup(cfg[m][2], cfg[m][1], cfg[m][0]);
            for (int c = 0; c < 8; c++) cyc(c);
        end
        repeat (24) begin
            r = $urandom;
            slow = r[0];
            setup(r[1], r[2], r[3] | r[4]);
            cyc(int'(r[7:5]));
        end
        end_of_test();
    end
endmodule : tb
`default_nettype wire
